//--- verilog/irm_pkg.sv
`default_nettype none
package irm_pkg;
    // Context count and register spacing
    localparam int          CTX_NUM           = 4;
    localparam int          CTX_W             = 2;
    localparam logic [15:0] CTX_STRIDE_MASK   = 16'h0060;
    localparam int          CTX_IDX_LSB       = 5;
    localparam logic [15:0] MATCH_BASE        = 16'h410C;
    localparam logic [15:0] CTL_BASE          = 16'h4108;
    localparam int          ADDR_W            = 16;

    // Match register fields
    localparam int          ACCEPT_TAG_ZERO_BIT  = 28;
    localparam int          ACCEPT_TAG_ONE_BIT   = 29;
    localparam int          START_CYCLE_LSB      = 12;
    localparam int          START_CYCLE_W        = 15;
    localparam int          SYNC_LSB             = 8;
    localparam int          SYNC_W               = 4;
    localparam int          SYNC_QUALIFY_BIT     = 6;
    localparam int          RX_CHANNEL_ID_LSB    = 0;
    localparam int          RX_CHANNEL_ID_W      = 6;
    localparam logic [31:0] MATCH_RW_MASK        = 32'hF7FFFF7F;
    localparam logic [31:0] MATCH_RESET          = 32'h00000000;

    // Context control register fields
    localparam int          CTL_CYC_EN_BIT    = 29;
    localparam int          CTL_RUN_BIT       = 15;
    localparam int          CTL_ACTIVE_BIT    = 10;
    localparam int          CTL_SYNC_HIT_BIT  = 2;
    localparam int          CTL_WAIT_LSB      = 0;
    localparam logic [1:0]  WAIT_FOR_SYNC     = 2'h3;

    // Cycle timer fields
    localparam int          TIMER_SECONDS_LSB     = 25;
    localparam int          TIMER_CYCLE_INDEX_LSB = 12;
    localparam int          TIMER_CMP_W           = 15;

    // Isochronous header word fields
    localparam int          HDR_TAG_LSB       = 14;
    localparam int          HDR_CHAN_LSB      = 8;
    localparam int          HDR_SYNC_LSB      = 0;
    localparam logic [1:0]  TAG_ONE           = 2'h1;
    localparam logic [1:0]  SYNC_TOP_ZERO     = 2'h0;

    // Buffer shape
    localparam int          FIFO_DEPTH        = 32;
    localparam int          FIFO_WIDTH        = 35;
endpackage : irm_pkg
`default_nettype wire

//--- verilog/irm_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module irm_fifo #(
    parameter int WIDTH = 35,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wrPtr;
        logic [AW-1:0]               rdPtr;
        logic [AW:0]                 count;
        logic                        outValid;
        logic [WIDTH-1:0]            outData;
    } irm_fifo_state_s;

    irm_fifo_state_s fifo_reg;
    irm_fifo_state_s fifo_next;
    logic            push;
    logic            pop;

    // Full only when every slot holds a word
    assign inReady  = ce && (fifo_reg.count != DEPTH[AW:0]);
    assign outValid = fifo_reg.outValid;
    assign outData  = fifo_reg.outData;
    assign push     = inValid && inReady;
    assign pop      = ce && (fifo_reg.count != '0) && (!fifo_reg.outValid || outReady);

    // Pointer, count and registered output stage
    always_comb begin
        fifo_next = fifo_reg;
        if (push) begin
            fifo_next.mem[fifo_reg.wrPtr] = inData;
            fifo_next.wrPtr = fifo_reg.wrPtr + 1'b1;
        end
        if (ce && outReady && fifo_reg.outValid) begin
            fifo_next.outValid = 1'b0;
        end
        if (pop) begin
            fifo_next.outData  = fifo_reg.mem[fifo_reg.rdPtr];
            fifo_next.outValid = 1'b1;
            fifo_next.rdPtr    = fifo_reg.rdPtr + 1'b1;
        end
        fifo_next.count = fifo_reg.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fifo_reg <= '0;
        end else if (ce) begin
            fifo_reg <= fifo_next;
        end
    end
endmodule : irm_fifo
`default_nettype wire

//--- verilog/irm_iso_rx_match.sv
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module irm_iso_rx_match
    import irm_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // Bus cycle timer value
    input  wire logic [31:0] cycleTimer,
    // Incoming isochronous packet words
    input  wire logic        pktValid,
    output logic             pktReady,
    input  wire logic [31:0] pktData,
    input  wire logic        pktFirst,
    input  wire logic        pktLast,
    // Accepted packet words toward DMA
    output logic             rxValid,
    input  wire logic        rxReady,
    output logic      [31:0] rxData,
    output logic      [1:0]  rxCtx,
    output logic             rxLast
);
    typedef struct packed {
        logic [CTX_NUM-1:0][31:0] matchReg;
        logic [CTX_NUM-1:0]       run;
        logic [CTX_NUM-1:0]       cycEn;
        logic [CTX_NUM-1:0][1:0]  waitFld;
        logic [CTX_NUM-1:0]       syncHit;
        logic [CTX_W-1:0]         curCtx;
        logic                     curKeep;
        logic                     dphWr;
        logic [ADDR_W-1:0]        dphAddr;
        logic [31:0]              rdata;
    } irm_state_s;

    irm_state_s              st_reg;
    irm_state_s              st_next;
    logic [CTX_NUM-1:0]      hit;
    logic [CTX_W-1:0]        winCtx;
    logic                    anyHit;
    logic                    keepNow;
    logic [CTX_W-1:0]        ctxNow;
    logic                    fifoInValid;
    logic                    fifoInReady;
    logic [FIFO_WIDTH-1:0]   fifoInData;
    logic [FIFO_WIDTH-1:0]   fifoOutData;
    logic [1:0]              hdrTag;
    logic [RX_CHANNEL_ID_W-1:0] hdrChan;
    logic [SYNC_W-1:0]       hdrSync;
    logic [TIMER_CMP_W-1:0]  timerNow;
    logic                    addrPhase;
    logic [ADDR_W-1:0]       aOff;
    logic [ADDR_W-1:0]       aBase;
    logic [CTX_W-1:0]        aCtx;
    logic [ADDR_W-1:0]       dBase;
    logic [CTX_W-1:0]        dCtx;

    // Header field extraction
    assign hdrTag   = pktData[HDR_TAG_LSB +: 2];
    assign hdrChan  = pktData[HDR_CHAN_LSB +: RX_CHANNEL_ID_W];
    assign hdrSync  = pktData[HDR_SYNC_LSB +: SYNC_W];
    // Low seconds bits then cycle index
    assign timerNow = {cycleTimer[TIMER_SECONDS_LSB +: 2],
                       cycleTimer[TIMER_CYCLE_INDEX_LSB +: 13]};

    // Per-context acceptance decision
    always_comb begin
        for (int i = 0; i < CTX_NUM; i++) begin
            hit[i] = st_reg.run[i]
                && (hdrChan == st_reg.matchReg[i][RX_CHANNEL_ID_LSB +: RX_CHANNEL_ID_W])
                && st_reg.matchReg[i][ACCEPT_TAG_ZERO_BIT + int'(hdrTag)]
                && !st_reg.cycEn[i];
            // Tag 01 narrowed only when qualify and its enable set
            if (st_reg.matchReg[i][SYNC_QUALIFY_BIT]
                && st_reg.matchReg[i][ACCEPT_TAG_ONE_BIT]
                && (hdrTag == TAG_ONE)
                && (hdrSync[SYNC_W-1 -: 2] != SYNC_TOP_ZERO)) begin
                hit[i] = 1'b0;
            end
            // Waiting for a sync value drops other sync values
            if ((st_reg.waitFld[i] == WAIT_FOR_SYNC) && !st_reg.syncHit[i]
                && (hdrSync != st_reg.matchReg[i][SYNC_LSB +: SYNC_W])) begin
                hit[i] = 1'b0;
            end
        end
    end

    // Lowest numbered matching context claims the packet
    always_comb begin
        anyHit = 1'b0;
        winCtx = '0;
        for (int i = CTX_NUM - 1; i >= 0; i--) begin
            if (hit[i]) begin
                anyHit = 1'b1;
                winCtx = CTX_W'(i);
            end
        end
    end

    // Keep or drop whole packet from its header decision
    assign keepNow     = pktFirst ? anyHit : st_reg.curKeep;
    assign ctxNow      = pktFirst ? winCtx : st_reg.curCtx;
    assign fifoInValid = ce && pktValid && keepNow;
    assign fifoInData  = {ctxNow, pktLast, pktData};
    assign pktReady    = ce && (!keepNow || fifoInReady);

    irm_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .ce       (ce),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .inData   (fifoInData),
        .outValid (rxValid),
        .outReady (rxReady),
        .outData  (fifoOutData)
    );

    assign rxData = fifoOutData[31:0];
    assign rxLast = fifoOutData[32];
    assign rxCtx  = fifoOutData[FIFO_WIDTH-1 -: CTX_W];

    // Bus decode: contexts sit 32 bytes apart
    assign addrPhase = hsel && hready && htrans[1];
    assign aOff      = haddr[ADDR_W-1:0];
    assign aBase     = aOff & ~CTX_STRIDE_MASK;
    assign aCtx      = aOff[CTX_IDX_LSB +: CTX_W];
    assign dBase     = st_reg.dphAddr & ~CTX_STRIDE_MASK;
    assign dCtx      = st_reg.dphAddr[CTX_IDX_LSB +: CTX_W];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st_reg.rdata;

    // Next-state logic for registers, packet tracking and bus
    always_comb begin
        st_next = st_reg;

        // Start-on-cycle releases once the timer equals the start value
        for (int i = 0; i < CTX_NUM; i++) begin
            if (st_reg.run[i] && st_reg.cycEn[i]
                && (timerNow == st_reg.matchReg[i][START_CYCLE_LSB +: START_CYCLE_W])) begin
                st_next.cycEn[i] = 1'b0;
            end
        end

        // Data phase write
        if (st_reg.dphWr) begin
            if (dBase == MATCH_BASE) begin
                st_next.matchReg[dCtx] = hwdata & MATCH_RW_MASK;
            end else if (dBase == CTL_BASE) begin
                st_next.run[dCtx]     = hwdata[CTL_RUN_BIT];
                st_next.cycEn[dCtx]   = hwdata[CTL_CYC_EN_BIT];
                st_next.waitFld[dCtx] = hwdata[CTL_WAIT_LSB +: 2];
                if (!hwdata[CTL_RUN_BIT]) begin
                    st_next.syncHit[dCtx] = 1'b0;
                end
            end
        end

        // Header taken: remember decision; a sync hit beats a clear
        if (pktValid && pktReady && pktFirst) begin
            st_next.curKeep = anyHit;
            st_next.curCtx  = winCtx;
            if (anyHit && (st_reg.waitFld[winCtx] == WAIT_FOR_SYNC)) begin
                st_next.syncHit[winCtx] = 1'b1;
            end
        end

        // Address phase: capture write, register read data
        st_next.dphWr = addrPhase && hwrite;
        if (addrPhase) begin
            st_next.dphAddr = aOff;
        end
        if (addrPhase && !hwrite) begin
            st_next.rdata = '0;
            if (aBase == MATCH_BASE) begin
                st_next.rdata = st_reg.matchReg[aCtx] & MATCH_RW_MASK;
            end else if (aBase == CTL_BASE) begin
                st_next.rdata[CTL_CYC_EN_BIT]   = st_reg.cycEn[aCtx];
                st_next.rdata[CTL_RUN_BIT]      = st_reg.run[aCtx];
                st_next.rdata[CTL_ACTIVE_BIT]   = st_reg.run[aCtx] && !st_reg.cycEn[aCtx];
                st_next.rdata[CTL_SYNC_HIT_BIT] = st_reg.syncHit[aCtx];
                st_next.rdata[CTL_WAIT_LSB +: 2] = st_reg.waitFld[aCtx];
            end
        end
    end

    // State register, frozen while clock enable is low
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_reg          <= '0;
            st_reg.matchReg <= {CTX_NUM{MATCH_RESET}};
        end else if (ce) begin
            st_reg <= st_next;
        end
    end
endmodule : irm_iso_rx_match
`default_nettype wire

//--- dv/irm_iso_rx_match_props.sv
`timescale 1ns/1ps
`default_nettype none
module irm_iso_rx_match_chk
    import irm_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        pktReady,
    input wire logic        rxValid,
    input wire logic        rxReady,
    input wire logic [31:0] rxData
);
    // Address phase decode
    logic take;
    logic isMatch;
    logic mapped;
    assign take    = hsel && hready && htrans[1];
    assign isMatch = (haddr[15:0] & ~CTX_STRIDE_MASK) == MATCH_BASE;
    assign mapped  = isMatch || ((haddr[15:0] & ~CTX_STRIDE_MASK) == CTL_BASE);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    AST_RSVD_ZERO: assert property (take && !hwrite && isMatch |=> !hrdata[27] && !hrdata[7])
        else $error("reserved match bit reads one");
    AST_UNMAPPED_ZERO: assert property (take && !hwrite && !mapped |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    AST_READBACK: assert property (take && !hwrite && isMatch && $past(take, 2) && $past(hwrite, 2)
        && haddr == $past(haddr, 2) |=> hrdata == ($past(hwdata, 2) & MATCH_RW_MASK))
        else $error("match readback differs from write");
    AST_RX_HOLD: assert property (rxValid && !rxReady |=> rxValid && $stable(rxData))
        else $error("output word dropped while stalled");
    AST_CE_READY: assert property (!ce |-> !pktReady)
        else $error("packet taken while clock enable low");
    AST_CE_FREEZE: assert property (!ce |=> $stable(rxValid) && $stable(hrdata))
        else $error("state moved while clock enable low");
    AST_RESET_QUIET: assert property ($rose(rst_n) |-> !rxValid && hrdata == 32'h0)
        else $error("outputs active out of reset");

    // Main scenarios
    cover property (take && hwrite && isMatch);
    cover property (take && !hwrite && !mapped);
    cover property (rxValid && rxReady);
    cover property (!ce && rxValid);
endmodule : irm_iso_rx_match_chk

bind irm_iso_rx_match irm_iso_rx_match_chk u_irm_iso_rx_match_chk (.clk_sys, .rst_n, .ce,
    .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .pktReady, .rxValid, .rxReady, .rxData);
`default_nettype wire

//--- dv/irm_pkt_src.sv
`timescale 1ns/1ps
`default_nettype none
module irm_pkt_src (
    input  wire logic        clk_sys,
    input  wire logic        pktReady,
    output logic             pktValid,
    output logic      [31:0] pktData,
    output logic             pktFirst,
    output logic             pktLast,
    output logic             stuck
);
    // Idle link at start
    initial begin
        pktValid = 1'b0;
        pktData = 32'h0;
        pktFirst = 1'b0;
        pktLast = 1'b0;
        stuck = 1'b0;
    end

    // Offer one word and hold it until taken
    task automatic put(input logic [31:0] w, input logic f, input logic l);
        int i;
        pktValid <= 1'b1;
        pktData <= w;
        pktFirst <= f;
        pktLast <= l;
        i = 0;
        // Ready is judged mid-cycle, so the word goes at the next rising edge
        @(negedge clk_sys);
        while (pktReady !== 1'b1 && i < 300) begin
            @(negedge clk_sys);
            i++;
        end
        @(posedge clk_sys);
        if (i >= 300) stuck <= 1'b1;
    endtask : put

    // Header then payload; released data shows the inverse
    task automatic send(input logic [31:0] hdr, input logic [31:0] dat);
        put(hdr, 1'b1, 1'b0);
        put(dat, 1'b0, 1'b1);
        pktValid <= 1'b0;
        pktData <= ~dat;
        pktLast <= 1'b0;
        @(posedge clk_sys);
    endtask : send
endmodule : irm_pkt_src
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import irm_pkg::*;
    typedef struct { logic [31:0] ctl, match, timer, hdr; logic acc; } irm_row_s;
    logic clk_sys, rst_n, ce, hsel, hwrite, rxReady, hready, hresp;
    logic pktValid, pktReady, pktFirst, pktLast, rxValid, rxLast, stuck;
    logic [31:0] haddr, hwdata, cycleTimer, q, hrdata, pktData, rxData;
    logic [1:0] htrans, rxCtx;
    logic [34:0] rxq[$];
    int err_count = 0;
    int n_compared = 0;
    irm_row_s rows[16] = '{
        '{32'h8000, 32'hF0000005, 0, 32'hC500, 1},
        '{32'h8000, 32'h80000005, 0, 32'h8500, 0},
        '{32'h8000, 32'h40000005, 0, 32'h8500, 1},
        '{32'h8000, 32'h10000005, 0, 32'h4500, 0},
        '{32'h8000, 32'h10000005, 0, 32'h0500, 1},
        '{32'h8000, 32'hF0000005, 0, 32'hC600, 0},
        '{32'h8000, 32'h20000045, 0, 32'h4504, 0},
        '{32'h8000, 32'h20000045, 0, 32'h4503, 1},
        '{32'h8000, 32'h90000045, 0, 32'hC50F, 1},
        '{32'h8000, 32'h40000045, 0, 32'h4500, 0},
        '{32'h8000, 32'h20000005, 0, 32'h450C, 1},
        '{32'h0, 32'hF0000005, 0, 32'hC500, 0},
        '{32'h20008000, 32'hF2ABC005, 32'hFAABD000, 32'hC500, 0},
        '{32'h20008000, 32'hF2ABC005, 32'hFAABCFFF, 32'hC500, 1},
        '{32'h8003, 32'hF0000505, 0, 32'hC504, 0},
        '{32'h8003, 32'hF0000505, 0, 32'hC505, 1}};

    irm_iso_rx_match u_irm_iso_rx_match (.clk_sys, .rst_n, .ce, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata,
        .cycleTimer, .pktValid, .pktReady, .pktData, .pktFirst, .pktLast, .rxValid,
        .rxReady, .rxData, .rxCtx, .rxLast);
    irm_pkt_src u_irm_pkt_src (.clk_sys, .pktReady, .pktValid, .pktData, .pktFirst,
        .pktLast, .stuck);

    // Clock and output capture
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (rst_n && rxValid && rxReady) rxq.push_back({rxCtx, rxLast, rxData});

    task automatic complete_run;
        if (err_count == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run

    task automatic chk(input string s, input logic [34:0] e, input logic [34:0] g);
        n_compared++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", s, e, g);
            err_count++;
        end
    endtask : chk

    // One AHB single transfer; read data lands in q
    task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
        int i;
        hsel <= 1'b1;
        haddr <= {16'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        i = 0;
        do begin @(posedge clk_sys); i++; end while (hready !== 1'b1 && i < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin @(posedge clk_sys); i++; end while (hready !== 1'b1 && i < 99);
        q = hrdata;
        if (i >= 99) begin err_count++; complete_run(); end
    endtask : bus

    // Send one packet and compare what leaves
    task automatic pkt(input logic [31:0] hdr, input logic acc);
        rxq.delete();
        u_irm_pkt_src.send(hdr, ~hdr);
        repeat (8) @(posedge clk_sys);
        chk("count", acc ? 35'h2 : 35'h0, 35'(rxq.size()));
        if (acc && rxq.size() == 2) begin
            chk("head", {3'h0, hdr}, rxq[0]);
            chk("tail", {3'h1, ~hdr}, rxq[1]);
        end
    endtask : pkt

    initial begin
        {rst_n, hsel, hwrite, htrans, haddr, hwdata, cycleTimer} = '0;
        {ce, rxReady} = 2'b11;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        foreach (rows[k]) begin
            cycleTimer <= rows[k].timer;
            bus(1'b1, CTL_BASE, rows[k].ctl);
            bus(1'b1, MATCH_BASE, rows[k].match);
            pkt(rows[k].hdr, rows[k].acc);
        end
        // Mid-run reset clears the match register
        rst_n <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        bus(1'b0, MATCH_BASE, 0);
        chk("match reset", {3'h0, MATCH_RESET}, {3'h0, q});
        // Fill buffer under stall, freeze, then drain
        bus(1'b1, CTL_BASE, 32'h8000);
        bus(1'b1, MATCH_BASE, 32'hF0000005);
        rxq.delete();
        rxReady <= 1'b0;
        fork
            for (int k = 0; k < 17; k++) u_irm_pkt_src.send(32'hC500, 32'(k));
            begin
                repeat (70) @(posedge clk_sys);
                chk("refused", 35'h2, {33'h0, pktValid, pktReady});
                ce <= 1'b0;
                repeat (3) @(posedge clk_sys);
                ce <= 1'b1;
                rxReady <= 1'b1;
            end
        join
        for (int i = 0; i < 100 && rxq.size() < 34; i++) @(posedge clk_sys);
        chk("drained", 35'd34, 35'(rxq.size()));
        for (int k = 0; k < 17 && rxq.size() == 34; k++) begin
            chk("fifo head", {3'h0, 32'hC500}, rxq[2 * k]);
            chk("fifo tail", {3'h1, 32'(k)}, rxq[2 * k + 1]);
        end
        chk("source stuck", 35'h0, {34'h0, stuck});
        // Reserved bits, separate contexts, unmapped space
        bus(1'b1, MATCH_BASE + 16'h20, 32'hFFFFFFFF);
        bus(1'b0, MATCH_BASE + 16'h20, 0);
        chk("match one", {3'h0, MATCH_RW_MASK}, {3'h0, q});
        bus(1'b0, MATCH_BASE + 16'h40, 0);
        chk("match two", 35'h0, {3'h0, q});
        bus(1'b1, 16'h4100, 32'hFFFFFFFF);
        bus(1'b0, 16'h4100, 0);
        chk("unmapped", 35'h0, {3'h0, q});
        complete_run();
    end
endmodule : tb
`default_nettype wire
